// >>> wdt_map.vh
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// Register offsets, byte addresses on the APB.
`define WDT_OFF_RSTCTL     8'h00
`define WDT_OFF_CFG        8'h04
`define WDT_OFF_CNT        8'h08

// Reset control register fields.
`define WDT_RSTCTL_IDLE    2
`define WDT_RSTCTL_SLEEP   3
`define WDT_RSTCTL_TOF     4
`define WDT_RSTCTL_SWEN    5

// Configuration and status readback fields.
`define WDT_CFG_FUSEEN     0
`define WDT_CFG_WIDE       1
`define WDT_CFG_POST_LO    4
`define WDT_CFG_POST_HI    7
`define WDT_CFG_RUN        8
`define WDT_CFG_LOWPWR     9

// Counter readback fields.
`define WDT_CNT_PRE_LO     0
`define WDT_CNT_PRE_HI     6
`define WDT_CNT_POST_LO    8
`define WDT_CNT_POST_HI    22

// Reset values.
`define WDT_RST_WORD       32'h0000_0000
`define WDT_RST_PRE        7'h00
`define WDT_RST_POST       15'h0000
`define WDT_RST_SEL        4'h0

// Prescaler terminal counts: divide by 32 and by 128.
`define WDT_PRE_SHORT_LAST 7'h1f
`define WDT_PRE_LONG_LAST  7'h7f

// Timing: system clock and nominal low-power oscillator rate.
`define WDT_CLK_HZ         200000000
`define WDT_OSC_HZ         32000
`define WDT_OSC_DIV        (`WDT_CLK_HZ / `WDT_OSC_HZ)

`endif

// >>> wdt_low_power_rc_osc_tick.v
`default_nettype none

// Stands in for the low-power RC oscillator: one tick per nominal
// oscillator period, produced only while the oscillator is enabled.
module wdt_osc_tick #(
   parameter DIV = 6250,
   parameter CW  = 13
)(
   input  wire          sys_clk,
   input  wire          rstSync_n,
   input  wire          oscEnable,
   output reg           tick
);

   reg  [CW-1:0] divCnt_q;
   wire [CW-1:0] divLast = DIV[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};

   // The divider rests at zero while off, so each enable starts a
   // full oscillator period rather than a stale partial one.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         divCnt_q <= {CW{1'b0}};
         tick     <= 1'b0;
      end else if (!oscEnable) begin
         divCnt_q <= {CW{1'b0}};
         tick     <= 1'b0;
      end else if (divCnt_q == divLast) begin
         divCnt_q <= {CW{1'b0}};
         tick     <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + {{(CW-1){1'b0}}, 1'b1};
         tick     <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// >>> wdt_timer.v
// The address map and the APB slave port are this design's own decisions.
`include "wdt_map.vh"
`default_nettype none

module wdt_timer #(
   parameter OSC_DIV  = `WDT_OSC_DIV,
   parameter DIV_W    = 13,
   parameter PRE_W    = 7,
   parameter POST_W   = 15
)(
   input  wire          sys_clk,
   input  wire          rst_n,
   input  wire [7:0]    paddr,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   input  wire          fuseWatchdogEnable,
   input  wire          prescaleWidthSelect,
   input  wire [3:0]    postscaleRatioSelect,
   input  wire          deviceReset,
   input  wire          powerSaveInstr,
   input  wire          sleepNotIdle,
   input  wire          clearWatchdogInstr,
   input  wire          oscSwitchDone,
   input  wire          exitLowPower,
   output reg           lowPowerRcOscEn,
   output reg           watchdogWake,
   output reg           watchdogResetReq,
   output reg           watchdogTimeoutFlag
);

   // Postscaler terminal count for a ratio code: two to the n, less one.
   function [POST_W-1:0] postLast;
      input [3:0] sel;
      reg   [POST_W:0] ratio;
      begin
         ratio    = {{POST_W{1'b0}}, 1'b1} << sel;
         postLast = ratio[POST_W-1:0] - {{(POST_W-1){1'b0}}, 1'b1};
      end
   endfunction

   reg               rstMeta_q;
   reg               rstSync_q;
   wire              rstSync_n;
   reg               cfgLoaded_q;
   reg               fuseEn_q;
   reg               wide_q;
   reg  [3:0]        postSel_q;
   reg               softEn_q;
   reg               sleepBit_q;
   reg               idleBit_q;
   reg               lowPower_q;
   reg  [PRE_W-1:0]  preCnt_q;
   reg  [POST_W-1:0] postCnt_q;
   wire              oscTick;
   wire              wdtOn;
   wire [PRE_W-1:0]  preLastVal;
   wire              preWrap;
   wire              postWrap;
   wire              clrCount;
   wire              timeout;
   wire              accessPh;
   wire              wrDone;
   wire              wrRstCtl;
   reg  [31:0]       rdWord;
   reg               rdErr;

   // Reset release passes two flops; everything else uses the copy.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   assign rstSync_n = rstSync_q;

   // Program-once configuration is caught in the first cycle after
   // reset release and then frozen, so later changes on the
   // configuration inputs cannot alter a running watchdog.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         cfgLoaded_q <= 1'b0;
         fuseEn_q    <= 1'b0;
         wide_q      <= 1'b0;
         postSel_q   <= `WDT_RST_SEL;
      end else if (!cfgLoaded_q) begin
         cfgLoaded_q <= 1'b1;
         fuseEn_q    <= fuseWatchdogEnable;
         wide_q      <= prescaleWidthSelect;
         postSel_q   <= postscaleRatioSelect;
      end
   end

   // Fuse enable cannot be overridden; soft enable only counts when
   // the fuse is clear.
   assign wdtOn = cfgLoaded_q & (fuseEn_q | softEn_q);

   // Oscillator model runs exactly while the watchdog is enabled.
   wdt_osc_tick #(
      .DIV       (OSC_DIV),
      .CW        (DIV_W)
   ) u_osc (
      .sys_clk   (sys_clk),
      .rstSync_n (rstSync_n),
      .oscEnable (wdtOn),
      .tick      (oscTick)
   );

   // APB handshake terms: one wait state, then the access completes.
   assign accessPh = psel & penable;
   assign wrDone   = accessPh & pready & pwrite;
   assign wrRstCtl = wrDone & (paddr == `WDT_OFF_RSTCTL);

   // Every cause of a counter clear other than a disable, in any order of arrival.
   // Clear-watchdog is honoured only in normal execution.
   assign clrCount = deviceReset
                   | oscSwitchDone
                   | powerSaveInstr
                   | exitLowPower
                   | (clearWatchdogInstr & ~lowPower_q);

   // Divide by 32 gives 1 ms, by 128 gives 4 ms at 32 kHz.
   assign preLastVal = wide_q ? `WDT_PRE_LONG_LAST
                              : `WDT_PRE_SHORT_LAST;
   assign preWrap  = oscTick & (preCnt_q == preLastVal);
   assign postWrap = preWrap & (postCnt_q == postLast(postSel_q));
   // A clear in the same cycle as the terminal count wins, since
   // software serviced the watchdog in time.
   assign timeout  = wdtOn & postWrap & ~clrCount;

   // Prescaler: advances on each oscillator tick and keeps counting
   // whatever the power mode of the core.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         preCnt_q <= `WDT_RST_PRE;
      end else if (clrCount || !wdtOn) begin
         preCnt_q <= `WDT_RST_PRE;
      end else if (preWrap) begin
         preCnt_q <= `WDT_RST_PRE;
      end else if (oscTick) begin
         preCnt_q <= preCnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
      end
   end

   // Postscaler: counts prescaler periods, giving ratios 1 to 32768.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         postCnt_q <= `WDT_RST_POST;
      end else if (clrCount || !wdtOn) begin
         postCnt_q <= `WDT_RST_POST;
      end else if (postWrap) begin
         postCnt_q <= `WDT_RST_POST;
      end else if (preWrap) begin
         postCnt_q <= postCnt_q + {{(POST_W-1){1'b0}}, 1'b1};
      end
   end

   // Power mode tracking: entry sets it, core exit or our own wake
   // ends it.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         lowPower_q <= 1'b0;
      end else if (deviceReset || exitLowPower) begin
         lowPower_q <= 1'b0;
      end else if (powerSaveInstr) begin
         lowPower_q <= 1'b1;
      end else if (timeout && lowPower_q) begin
         lowPower_q <= 1'b0;
      end
   end

   // Time-out outcome: a wake in low power, a reset request otherwise.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         watchdogWake     <= 1'b0;
         watchdogResetReq <= 1'b0;
      end else begin
         watchdogWake     <= timeout & lowPower_q;
         watchdogResetReq <= timeout & ~lowPower_q;
      end
   end

   // Software enable: device reset clears it, and takes priority
   // over a write landing in the same cycle.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         softEn_q <= 1'b0;
      end else if (deviceReset) begin
         softEn_q <= 1'b0;
      end else if (wrRstCtl) begin
         softEn_q <= pwdata[`WDT_RSTCTL_SWEN];
      end
   end

   // Time-out flag survives device reset so that software can tell
   // why it restarted; a time-out in the clearing cycle still sets it.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         watchdogTimeoutFlag <= 1'b0;
      end else if (timeout) begin
         watchdogTimeoutFlag <= 1'b1;
      end else if (wrRstCtl) begin
         watchdogTimeoutFlag <= pwdata[`WDT_RSTCTL_TOF];
      end
   end

   // Sleep and idle status: set on power-save entry and left set
   // after a wake; only software removes them.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         sleepBit_q <= 1'b0;
         idleBit_q  <= 1'b0;
      end else if (powerSaveInstr) begin
         sleepBit_q <= sleepBit_q | sleepNotIdle;
         idleBit_q  <= idleBit_q | ~sleepNotIdle;
      end else if (wrRstCtl) begin
         sleepBit_q <= pwdata[`WDT_RSTCTL_SLEEP];
         idleBit_q  <= pwdata[`WDT_RSTCTL_IDLE];
      end
   end

   // Oscillator enable follows the watchdog enable.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         lowPowerRcOscEn <= 1'b0;
      end else begin
         lowPowerRcOscEn <= wdtOn;
      end
   end

   // Read mux; unmapped addresses return zero with an error.
   always @* begin
      rdWord = `WDT_RST_WORD;
      rdErr  = 1'b0;
      case (paddr)
         `WDT_OFF_RSTCTL: begin
            rdWord[`WDT_RSTCTL_IDLE]  = idleBit_q;
            rdWord[`WDT_RSTCTL_SLEEP] = sleepBit_q;
            rdWord[`WDT_RSTCTL_TOF]   = watchdogTimeoutFlag;
            rdWord[`WDT_RSTCTL_SWEN]  = softEn_q;
         end
         `WDT_OFF_CFG: begin
            rdWord[`WDT_CFG_FUSEEN] = fuseEn_q;
            rdWord[`WDT_CFG_WIDE]   = wide_q;
            rdWord[`WDT_CFG_POST_HI:`WDT_CFG_POST_LO] = postSel_q;
            rdWord[`WDT_CFG_RUN]    = wdtOn;
            rdWord[`WDT_CFG_LOWPWR] = lowPower_q;
         end
         `WDT_OFF_CNT: begin
            rdWord[`WDT_CNT_PRE_HI:`WDT_CNT_PRE_LO]   = preCnt_q;
            rdWord[`WDT_CNT_POST_HI:`WDT_CNT_POST_LO] = postCnt_q;
         end
         default: begin
            rdErr = 1'b1;
         end
      endcase
   end

   // APB answer: pready rises one cycle into the access phase and
   // drops after the completing edge. Registered read data costs a
   // wait state but keeps every output straight from a flop.
   always @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `WDT_RST_WORD;
      end else if (accessPh && !pready) begin
         pready  <= 1'b1;
         pslverr <= rdErr;
         prdata  <= pwrite ? `WDT_RST_WORD : rdWord;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `WDT_RST_WORD;
      end
   end

endmodule

`default_nettype wire

// >>> wdt_core_model.sv
`default_nettype none
// Stand-in for the core and clock-switch logic. Codes from the bench:
// 1 sleep, 2 idle, 3 clear instruction, 4 clock switch done.
module wdt_core_model (
   input  wire logic       sys_clk,
   input  wire logic [2:0] cmd,
   input  wire logic       watchdogWake,
   input  wire logic       watchdogResetReq,
   output var  logic       deviceReset,
   output var  logic       powerSaveInstr,
   output var  logic       sleepNotIdle,
   output var  logic       clearWatchdogInstr,
   output var  logic       oscSwitchDone,
   output var  logic       exitLowPower
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet until the first edge, so the block never sees an unknown event.
   initial begin
      {deviceReset, powerSaveInstr, sleepNotIdle} = 3'h0;
      {clearWatchdogInstr, oscSwitchDone, exitLowPower} = 3'h0;
   end
   // A reset request always returns as a device reset, a wake as resume.
   always @(posedge sys_clk) begin
      deviceReset <= watchdogResetReq;
      powerSaveInstr <= cmd == 3'h1 || cmd == 3'h2;
      sleepNotIdle <= cmd == 3'h1;
      clearWatchdogInstr <= cmd == 3'h3;
      oscSwitchDone <= cmd == 3'h4;
      exitLowPower <= watchdogWake;
   end
endmodule
`default_nettype wire

// >>> wdt_timer_asserts.sv
`default_nettype none
// Pin-level watch on time-out pulses, the flag and the bus wait state.
module wdt_timer_asserts #(
   parameter OSC_DIV = 4
)(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        deviceReset,
   input wire logic        powerSaveInstr,
   input wire logic        oscSwitchDone,
   input wire logic        exitLowPower,
   input wire logic        lowPowerRcOscEn,
   input wire logic        watchdogWake,
   input wire logic        watchdogResetReq,
   input wire logic        watchdogTimeoutFlag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sinceClr_q;
   wire         toEv = watchdogWake | watchdogResetReq;
   // A completed software write of zero to the time-out flag.
   wire         swClr = psel & penable & pready & pwrite
                        & (paddr == 8'h00) & ~pwdata[4];
   // Cycles since a restart event; it saturates, since a wrap would make
   // a long quiet stretch look like a fresh start.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sinceClr_q <= 16'h0000;
      end else if (deviceReset | powerSaveInstr | oscSwitchDone
                   | exitLowPower) begin
         sinceClr_q <= 16'h0000;
      end else if (sinceClr_q != 16'hffff) begin
         sinceClr_q <= sinceClr_q + 16'h0001;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   chk_min_period: assert property (
      toEv |-> sinceClr_q >= 16'(OSC_DIV * 31))
      else $error("Time-out came too soon after a clear.");
   chk_wake_pulse: assert property (
      watchdogWake |=> !watchdogWake)
      else $error("Wake held longer than one cycle.");
   chk_reset_pulse: assert property (
      watchdogResetReq |=> !watchdogResetReq)
      else $error("Reset request held longer than one cycle.");
   chk_one_outcome: assert property (
      toEv |-> watchdogTimeoutFlag && !(watchdogWake && watchdogResetReq))
      else $error("Time-out without flag or with both outcomes.");
   chk_flag_sticky: assert property (
      $fell(watchdogTimeoutFlag) |-> $past(swClr))
      else $error("Time-out flag fell without a software clear.");
   chk_osc_running: assert property (
      $rose(watchdogTimeoutFlag) |-> lowPowerRcOscEn)
      else $error("Time-out while the oscillator was off.");
   chk_stopped_quiet: assert property (
      !lowPowerRcOscEn [*2] |-> !toEv)
      else $error("Time-out while the watchdog was stopped.");
   chk_apb_wait: assert property (
      psel && $rose(penable) |-> !pready ##1 pready)
      else $error("Bus answer not after exactly one wait state.");
endmodule
bind wdt_timer wdt_timer_asserts #(.OSC_DIV(OSC_DIV)) u_chk (.sys_clk,
   .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
   .deviceReset, .powerSaveInstr, .oscSwitchDone, .exitLowPower,
   .lowPowerRcOscEn, .watchdogWake, .watchdogResetReq,
   .watchdogTimeoutFlag);
`default_nettype wire

// >>> tb_watchdog_timer.sv
`default_nettype none
`define CHK(nm, ex, gt) begin \
   comparisons++; \
   if ((gt) !== (ex)) begin \
      error_cnt++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
   end \
end
module tb_watchdog_timer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 4;
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        fuseWatchdogEnable, prescaleWidthSelect, deviceReset;
   logic        powerSaveInstr, sleepNotIdle, clearWatchdogInstr;
   logic        oscSwitchDone, exitLowPower, lowPowerRcOscEn;
   logic        watchdogWake, watchdogResetReq, watchdogTimeoutFlag;
   logic [3:0]  postscaleRatioSelect;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  cmd;
   logic [16:0] lfsr;
   logic [64:0] e;
   logic [64:0] apbQ[$];
   logic [1:0]  evQ[$];
   int          error_cnt, comparisons, cycles;

   wdt_timer #(.OSC_DIV(DIV)) dut_u (.sys_clk, .rst_n, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .fuseWatchdogEnable, .prescaleWidthSelect, .postscaleRatioSelect,
      .deviceReset, .powerSaveInstr, .sleepNotIdle, .clearWatchdogInstr,
      .oscSwitchDone, .exitLowPower, .lowPowerRcOscEn, .watchdogWake,
      .watchdogResetReq, .watchdogTimeoutFlag);
   wdt_core_model core_u (.sys_clk, .cmd, .watchdogWake, .watchdogResetReq,
      .deviceReset, .powerSaveInstr, .sleepNotIdle, .clearWatchdogInstr,
      .oscSwitchDone, .exitLowPower);

   // Free-running system clock.
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   function automatic logic [16:0] nxt(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction

   task automatic summarize();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Pairs each finished transfer and time-out pulse with the oldest note.
   // The cycle ceiling sits far beyond the longest planned wait.
   always @(posedge sys_clk) begin
      cycles++;
      if (psel && penable && pready) begin
         e = apbQ.pop_front();
         `CHK("pslverr", e[64], pslverr)
         `CHK("prdata", e[31:0], prdata & e[63:32])
      end
      if (watchdogWake || watchdogResetReq) begin
         e[1:0] = evQ.pop_front();
         `CHK("event", e[1:0], {watchdogWake, watchdogResetReq})
      end
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   // Note is a {slave error, data mask, data} triple; request held to ready.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [64:0] x);
      apbQ.push_back(x);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, {a == 8'h0c, 32'hffff_ffff, d});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, {a == 8'h0c, 64'h0});
   endtask

   // Options are taken once after release, so each set needs a reset.
   task automatic restart(input logic f, input logic [3:0] p);
      rst_n <= 1'b0;
      fuseWatchdogEnable <= f;
      prescaleWidthSelect <= p[0];
      postscaleRatioSelect <= p;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask

   // Requests one core action, then times the next time-out against a
   // window of t ticks; the first tick may come up to DIV-1 cycles early.
   task automatic timed(input logic [2:0] c, input logic [1:0] k,
                        input int t);
      int n;
      evQ.push_back(k);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 3'h0;
      n = 0;
      while (!(watchdogWake || watchdogResetReq) && n < t * DIV + 9) begin
         @(posedge sys_clk);
         n++;
      end
      `CHK("period", 1'b1, n >= (t - 1) * DIV && n <= t * DIV + 4)
      @(posedge sys_clk);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, cmd} = '0;
      {fuseWatchdogEnable, prescaleWidthSelect, postscaleRatioSelect} = '0;
      {error_cnt, comparisons, cycles} = '0;
      lfsr = nxt(17'h183f7);
      restart(1'b0, 4'h0);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      wr(8'h04, {15'h0, lfsr});
      wr(8'h0c, {lfsr, 15'h0});
      rd(8'h0c, 32'h0);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h20);
      rd(8'h04, 32'h100);
      repeat (50) @(posedge sys_clk);
      timed(3'h3, 2'b01, 32);
      rd(8'h00, 32'h10);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h0);
      for (int i = 1; i <= 2; i++) begin
         wr(8'h00, 32'h20);
         repeat (40) @(posedge sys_clk);
         timed(3'(i), 2'b10, 32);
         rd(8'h00, i == 1 ? 32'h38 : 32'h34);
         wr(8'h00, 32'h20);
      end
      timed(3'h4, 2'b01, 32);
      rd(8'h00, 32'h10);
      wr(8'h00, 32'h20);
      wr(8'h00, 32'h0);
      repeat (300) @(posedge sys_clk);
      rd(8'h04, 32'h0);
      restart(1'b1, 4'h1);
      wr(8'h00, 32'h0);
      timed(3'h3, 2'b01, 256);
      rd(8'h04, 32'h113);
      restart(1'b1, 4'h2);
      timed(3'h3, 2'b01, 128);
      for (int k = 0; k < 16; k++) begin
         restart(1'b1, 4'(k));
         rd(8'h04, 32'(32'h101 | k << 4 | (k & 1) << 1));
      end
      summarize();
   end
endmodule
`default_nettype wire
